/* rtl/irupkg.sv */
package irup_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PC_W       = 16;
  localparam int WORD_W     = 16;
  localparam int ACC_W      = 32;
  localparam int STACK_D    = 8;
  localparam int STACK_AW   = 3;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int GIM_POS    = 11;
  localparam int FLAG_POS   = 12;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [PC_W-1:0]   PC_RST    = 16'h0000;
  localparam logic [WORD_W-1:0] WORD_RST  = 16'h0000;
  localparam logic [ACC_W-1:0]  ACC_RST   = 32'h00000000;
  localparam logic [WORD_W-1:0] STATUS0_RST = 16'h0800;

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam logic [2:0] SLOT_WORDS   = 3'h2;
  localparam logic [2:0] RET_CYCLES   = 3'h4;

  typedef enum logic [1:0] {
    CMD_NONE,
    CMD_COND_RET,
    CMD_RET_EN,
    CMD_RET_INT
  } irup_cmd_t;

endpackage : irup_pkg

/* rtl/irup_unit.sv */
`timescale 1ns/1ps

module irup_unit (
  input  wire logic                          CLOCK_I,
  input  wire logic                          RST_I,
  input  wire logic                          CE_I,
  input  wire logic                          ISSUE_I,
  input  wire irup_pkg::irup_cmd_t           CMD_I,
  input  wire logic                          USE_CARRY_I,
  input  wire logic                          CARRY_I,
  input  wire logic                          SLOT_EXEC_I,
  input  wire logic                          PUSH_I,
  input  wire logic [irup_pkg::PC_W-1:0]     PUSH_VAL_I,
  input  wire logic                          INT_ENTRY_I,
  input  wire logic                          WR_EN_I,
  input  wire logic [irup_pkg::ACC_W-1:0]    ACC_I,
  input  wire logic [irup_pkg::ACC_W-1:0]    ACC_BUF_I,
  input  wire logic [irup_pkg::ACC_W-1:0]    PRODUCT_I,
  input  wire logic [irup_pkg::WORD_W-1:0]   STATUS0_I,
  input  wire logic [irup_pkg::WORD_W-1:0]   STATUS1_I,
  input  wire logic [irup_pkg::WORD_W-1:0]   MODE_I,
  input  wire logic [irup_pkg::WORD_W-1:0]   COMPARE_I,
  input  wire logic [irup_pkg::WORD_W-1:0]   INDEX_I,
  input  wire logic [irup_pkg::WORD_W-1:0]   TEMP0_I,
  input  wire logic [irup_pkg::WORD_W-1:0]   TEMP1_I,
  input  wire logic [irup_pkg::WORD_W-1:0]   TEMP2_I,
  output logic                               BUSY_O,
  output logic                               PC_LOAD_O,
  output logic [irup_pkg::PC_W-1:0]          PC_O,
  output logic                               FLUSH_O,
  output logic [irup_pkg::PC_W-1:0]          STACK_TOP_O,
  output logic [irup_pkg::ACC_W-1:0]         ACC_O,
  output logic [irup_pkg::ACC_W-1:0]         ACC_BUF_O,
  output logic [irup_pkg::ACC_W-1:0]         PRODUCT_O,
  output logic [irup_pkg::WORD_W-1:0]        STATUS0_O,
  output logic [irup_pkg::WORD_W-1:0]        STATUS1_O,
  output logic [irup_pkg::WORD_W-1:0]        MODE_O,
  output logic [irup_pkg::WORD_W-1:0]        COMPARE_O,
  output logic [irup_pkg::WORD_W-1:0]        INDEX_O,
  output logic [irup_pkg::WORD_W-1:0]        TEMP0_O,
  output logic [irup_pkg::WORD_W-1:0]        TEMP1_O,
  output logic [irup_pkg::WORD_W-1:0]        TEMP2_O
);

  typedef enum logic [1:0] {
    IDLE,
    SLOTS,
    SPEC
  } irup_state_t;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [irup_pkg::PC_W-1:0]   stack_r [irup_pkg::STACK_D];
  irup_state_t                 state_r;
  logic [2:0]                  cnt_r;
  logic                        restore_r;
  logic                        clr_mask_r;
  logic [irup_pkg::ACC_W-1:0]  sh_acc_r;
  logic [irup_pkg::ACC_W-1:0]  sh_accumulator_buffer_r;
  logic [irup_pkg::ACC_W-1:0]  sh_prod_r;
  logic [irup_pkg::WORD_W-1:0] sh_st0_r;
  logic [irup_pkg::WORD_W-1:0] sh_st1_r;
  logic [irup_pkg::WORD_W-1:0] sh_mode_r;
  logic [irup_pkg::WORD_W-1:0] sh_cmp_r;
  logic [irup_pkg::WORD_W-1:0] sh_idx_r;
  logic [irup_pkg::WORD_W-1:0] sh_t0_r;
  logic [irup_pkg::WORD_W-1:0] sh_t1_r;
  logic [irup_pkg::WORD_W-1:0] sh_t2_r;

  logic                        take;
  logic                        cond_ok;
  logic                        pop;
  logic                        pop_go;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign cond_ok = !USE_CARRY_I || CARRY_I;
  assign take    = CE_I && ISSUE_I && (state_r == IDLE) && (CMD_I != irup_pkg::CMD_NONE)
                   && ((CMD_I != irup_pkg::CMD_COND_RET) || cond_ok);
  // The pop and PC load happen on the last cycle of the sequence.
  assign pop     = CE_I && (state_r != IDLE) && (cnt_r == 3'h1);
  // A delayed return pops only once its second slot word has executed.
  assign pop_go  = pop && ((state_r != SLOTS) || SLOT_EXEC_I);
  assign BUSY_O  = (state_r != IDLE);
  assign STACK_TOP_O = stack_r[0];

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      state_r    <= IDLE;
      cnt_r      <= 3'h0;
    end else if (CE_I) begin
      case (state_r)
        IDLE: begin
          if (take) begin
            if (CMD_I == irup_pkg::CMD_COND_RET) begin
              state_r <= SLOTS;
              cnt_r   <= irup_pkg::SLOT_WORDS;
            end else begin
              state_r <= SPEC;
              cnt_r   <= irup_pkg::RET_CYCLES - 3'h1;
            end
          end
        end
        SLOTS: begin
          // Only executed delay-slot words advance the count.
          if (SLOT_EXEC_I) begin
            cnt_r <= cnt_r - 3'h1;
            if (cnt_r == 3'h1) begin
              state_r <= IDLE;
            end
          end
        end
        SPEC: begin
          cnt_r <= cnt_r - 3'h1;
          if (cnt_r == 3'h1) begin
            state_r <= IDLE;
          end
        end
        default: begin
          state_r <= IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Return flavour
  // ----------------------------------------------------------------
  // Latched at the take edge and held until the next return is taken.
  // Only the delayed conditional return leaves the context untouched.
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      restore_r  <= 1'b0;
      clr_mask_r <= 1'b0;
    end else if (CE_I && take) begin
      restore_r  <= (CMD_I != irup_pkg::CMD_COND_RET);
      clr_mask_r <= (CMD_I == irup_pkg::CMD_RET_EN);
    end
  end

  // ----------------------------------------------------------------
  // Program counter and flush
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      PC_LOAD_O <= 1'b0;
      PC_O      <= irup_pkg::PC_RST;
      FLUSH_O   <= 1'b0;
    end else if (CE_I) begin
      PC_LOAD_O <= 1'b0;
      FLUSH_O   <= 1'b0;
      if (pop_go) begin
        PC_O      <= stack_r[0];
        PC_LOAD_O <= 1'b1;
        FLUSH_O   <= (state_r == SPEC);
      end
    end
  end

  // ----------------------------------------------------------------
  // Hardware stack
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      for (int i = 0; i < irup_pkg::STACK_D; i++) begin
        stack_r[i] <= irup_pkg::PC_RST;
      end
    end else if (CE_I) begin
      // A pop wins over a push in the same cycle.
      // The bottom level is not written, so the deepest entry is duplicated.
      if (pop_go) begin
        for (int i = 0; i < irup_pkg::STACK_D - 1; i++) begin
          stack_r[i] <= stack_r[i+1];
        end
      end else if (PUSH_I) begin
        stack_r[0] <= PUSH_VAL_I;
        for (int i = 1; i < irup_pkg::STACK_D; i++) begin
          stack_r[i] <= stack_r[i-1];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Shadow capture at interrupt entry
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      sh_acc_r  <= irup_pkg::ACC_RST;
      sh_accumulator_buffer_r <= irup_pkg::ACC_RST;
      sh_prod_r <= irup_pkg::ACC_RST;
      sh_st0_r  <= irup_pkg::STATUS0_RST;
      sh_st1_r  <= irup_pkg::WORD_RST;
      sh_mode_r <= irup_pkg::WORD_RST;
      sh_cmp_r  <= irup_pkg::WORD_RST;
      sh_idx_r  <= irup_pkg::WORD_RST;
      sh_t0_r   <= irup_pkg::WORD_RST;
      sh_t1_r   <= irup_pkg::WORD_RST;
      sh_t2_r   <= irup_pkg::WORD_RST;
    end else if (CE_I && INT_ENTRY_I) begin
      sh_acc_r  <= ACC_I;
      sh_accumulator_buffer_r <= ACC_BUF_I;
      sh_prod_r <= PRODUCT_I;
      sh_st0_r  <= STATUS0_I;
      sh_st1_r  <= STATUS1_I;
      sh_mode_r <= MODE_I;
      sh_cmp_r  <= COMPARE_I;
      sh_idx_r  <= INDEX_I;
      sh_t0_r   <= TEMP0_I;
      sh_t1_r   <= TEMP1_I;
      sh_t2_r   <= TEMP2_I;
    end
  end

  // ----------------------------------------------------------------
  // Working registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      ACC_O     <= irup_pkg::ACC_RST;
      ACC_BUF_O <= irup_pkg::ACC_RST;
      PRODUCT_O <= irup_pkg::ACC_RST;
      MODE_O    <= irup_pkg::WORD_RST;
      COMPARE_O <= irup_pkg::WORD_RST;
      INDEX_O   <= irup_pkg::WORD_RST;
      TEMP0_O   <= irup_pkg::WORD_RST;
      TEMP1_O   <= irup_pkg::WORD_RST;
      TEMP2_O   <= irup_pkg::WORD_RST;
    end else if (CE_I) begin
      // Restore has priority over an ordinary core write.
      if (pop_go && restore_r) begin
        ACC_O     <= sh_acc_r;
        ACC_BUF_O <= sh_accumulator_buffer_r;
        PRODUCT_O <= sh_prod_r;
        MODE_O    <= sh_mode_r;
        COMPARE_O <= sh_cmp_r;
        INDEX_O   <= sh_idx_r;
        TEMP0_O   <= sh_t0_r;
        TEMP1_O   <= sh_t1_r;
        TEMP2_O   <= sh_t2_r;
      end else if (WR_EN_I) begin
        ACC_O     <= ACC_I;
        ACC_BUF_O <= ACC_BUF_I;
        PRODUCT_O <= PRODUCT_I;
        MODE_O    <= MODE_I;
        COMPARE_O <= COMPARE_I;
        INDEX_O   <= INDEX_I;
        TEMP0_O   <= TEMP0_I;
        TEMP1_O   <= TEMP1_I;
        TEMP2_O   <= TEMP2_I;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status words
  // ----------------------------------------------------------------
  // Status word zero: on the enabling return the mask comes back cleared.
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      STATUS0_O <= irup_pkg::STATUS0_RST;
    end else if (CE_I) begin
      if (pop_go && restore_r) begin
        STATUS0_O <= sh_st0_r;
        STATUS0_O[irup_pkg::GIM_POS] <= sh_st0_r[irup_pkg::GIM_POS] & ~clr_mask_r;
      end else if (WR_EN_I) begin
        STATUS0_O <= STATUS0_I;
      end
    end
  end

  // Status word one: the external flag keeps its live value across a restore.
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      STATUS1_O <= irup_pkg::WORD_RST;
    end else if (CE_I) begin
      if (pop_go && restore_r) begin
        STATUS1_O <= sh_st1_r;
        STATUS1_O[irup_pkg::FLAG_POS] <= STATUS1_I[irup_pkg::FLAG_POS];
      end else if (WR_EN_I) begin
        STATUS1_O <= STATUS1_I;
      end
    end
  end

endmodule : irup_unit

/* verif/irup_assertions.sv */
`timescale 1ns/1ps
module irup_assertions (
  input wire logic                          CLOCK_I,
  input wire logic                          RST_I,
  input wire logic                          CE_I,
  input wire logic                          ISSUE_I,
  input wire irup_pkg::irup_cmd_t           CMD_I,
  input wire logic                          USE_CARRY_I,
  input wire logic                          CARRY_I,
  input wire logic                          SLOT_EXEC_I,
  input wire logic                          BUSY_O,
  input wire logic                          PC_LOAD_O,
  input wire logic                          FLUSH_O,
  input wire logic [irup_pkg::PC_W-1:0]     PC_O,
  input wire logic [irup_pkg::PC_W-1:0]     STACK_TOP_O,
  input wire logic [irup_pkg::WORD_W-1:0]   STATUS0_O
);
  // ------------------------------------------------------------
  // Return sequencing
  // ------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  wire take_w = CE_I && ISSUE_I && !BUSY_O;
  wire cd_w   = take_w && CMD_I == irup_pkg::CMD_COND_RET;
  wire go_w   = !USE_CARRY_I || CARRY_I;
  wire en_w   = take_w && CMD_I == irup_pkg::CMD_RET_EN;
  wire full_w = en_w || (take_w && CMD_I == irup_pkg::CMD_RET_INT);
  wire mask_w = STATUS0_O[irup_pkg::GIM_POS];
  sequence busy_run; BUSY_O [*3]; endsequence
  sequence jump_out; PC_LOAD_O && FLUSH_O && !BUSY_O; endsequence
  ret_timing_a: assert property (full_w |=> busy_run ##1 jump_out)
    else $error("long return timing wrong");
  flush_pair_a: assert property (FLUSH_O |-> PC_LOAD_O ##1 !FLUSH_O)
    else $error("flush without a single PC load");
  load_top_a: assert property (PC_LOAD_O |-> PC_O == $past(STACK_TOP_O))
    else $error("PC not loaded from stack top");
  mask_clr_a: assert property (en_w |-> ##4 !mask_w)
    else $error("mask still set after enabling return");
  cond_skip_a: assert property (cd_w && !go_w |=> !BUSY_O && !PC_LOAD_O)
    else $error("false conditional return started");
  cond_take_a: assert property (cd_w && go_w |=> BUSY_O && !PC_LOAD_O)
    else $error("true conditional return not started");
  slot_done_a: assert property (PC_LOAD_O && !FLUSH_O |->
    $past(SLOT_EXEC_I) && $past(BUSY_O))
    else $error("delayed return jumped before its slots");
  busy_end_a: assert property ($fell(BUSY_O) |-> PC_LOAD_O)
    else $error("return ended without PC load");
endmodule : irup_assertions

/* verif/irup_unit_tb.sv */
`timescale 1ns/1ps
module irup_unit_tb;
  logic                clock = 1'b0, rst = 1'b1, issue = 1'b0, use_carry = 1'b0, carry = 1'b0;
  logic                slot = 1'b0, push = 1'b0, int_entry = 1'b0, wr_en = 1'b0;
  logic [15:0]         push_val = 16'h0000, seed = 16'h92bb, stk [8], xs [8], es [8];
  logic [31:0]         xl [3], el [3];
  wire  [31:0]         yl [3];
  wire  [15:0]         ys [8], pc, top;
  wire                 busy, load, flush;
  irup_pkg::irup_cmd_t cmd = irup_pkg::CMD_NONE;
  int                  n_fail = 0, samples_checked = 0;
  logic                rd, ret_en, ce = 1'b1;

  irup_unit u_dut (.CLOCK_I(clock), .RST_I(rst), .CE_I(ce), .ISSUE_I(issue), .CMD_I(cmd),
    .USE_CARRY_I(use_carry), .CARRY_I(carry), .SLOT_EXEC_I(slot), .PUSH_I(push),
    .PUSH_VAL_I(push_val), .INT_ENTRY_I(int_entry), .WR_EN_I(wr_en), .ACC_I(xl[0]),
    .ACC_BUF_I(xl[1]), .PRODUCT_I(xl[2]), .STATUS0_I(xs[0]), .STATUS1_I(xs[1]),
    .MODE_I(xs[2]),
    .COMPARE_I(xs[3]), .INDEX_I(xs[4]), .TEMP0_I(xs[5]), .TEMP1_I(xs[6]), .TEMP2_I(xs[7]),
    .BUSY_O(busy), .PC_LOAD_O(load), .PC_O(pc), .FLUSH_O(flush), .STACK_TOP_O(top),
    .ACC_O(yl[0]), .ACC_BUF_O(yl[1]), .PRODUCT_O(yl[2]), .STATUS0_O(ys[0]),
    .STATUS1_O(ys[1]),
    .MODE_O(ys[2]), .COMPARE_O(ys[3]), .INDEX_O(ys[4]), .TEMP0_O(ys[5]), .TEMP1_O(ys[6]),
    .TEMP2_O(ys[7]));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  always #25 clock = ~clock;
  function automatic logic [15:0] lf(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lf
  // Restored status words: mask cleared on the enabling return, flag bit stays live.
  function automatic logic [15:0] rst_exp(input int i, input logic en);
    logic [15:0] v;
    v = es[i];
    if (i == 0 && en) v[irup_pkg::GIM_POS] = 1'b0;
    if (i == 1) v[irup_pkg::FLAG_POS] = xs[1][irup_pkg::FLAG_POS];
    return v;
  endfunction : rst_exp
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic ctx_rand;
    for (int i = 0; i < 11; i++) begin
      seed = lf(seed);
      if (i < 3) xl[i] = {seed, lf(seed)};
      else xs[i-3] = seed;
    end
  endtask : ctx_rand
  task automatic test_done;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done

  initial begin
    #1000000;
    n_fail++;
    test_done;
  end

  initial begin
    for (int i = 0; i < 8; i++) begin
      stk[i] = 16'h0000;
      xs[i] = 16'h0000;
      if (i < 3) xl[i] = 32'h00000000;
    end
    tick(3);
    rst = 1'b0;
    chk(ys[0], 16'h0800);
    chk(pc, 16'h0000);
    // With the clock enable low a push must leave the stack untouched.
    ce = 1'b0;
    push = 1'b1;
    push_val = 16'h5a5a;
    tick(2);
    push = 1'b0;
    ce = 1'b1;
    chk(top, 16'h0000);
    for (int r = 0; r < 14; r++) begin
      if (r < 4) repeat (2) begin
        seed = lf(seed);
        push = 1'b1;
        push_val = seed;
        for (int i = 7; i > 0; i--) stk[i] = stk[i-1];
        stk[0] = seed;
        tick(1);
      end
      push = 1'b0;
      ctx_rand;
      int_entry = 1'b1;
      tick(1);
      int_entry = 1'b0;
      el = xl;
      es = xs;
      ctx_rand;
      wr_en = 1'b1;
      tick(1);
      wr_en = 1'b0;
      chk(yl[0], xl[0]);
      seed = lf(seed);
      cmd = irup_pkg::irup_cmd_t'(2'(1 + r % 3));
      rd = (cmd == irup_pkg::CMD_COND_RET);
      ret_en = (cmd == irup_pkg::CMD_RET_EN);
      use_carry = seed[0] | (r == 3);
      carry = seed[1] & (r != 3);
      issue = 1'b1;
      tick(1);
      // Round 5 keeps requesting while busy; those requests must be ignored.
      issue = (r == 5);
      if (rd && use_carry && !carry) begin
        tick(2);
        chk({load, top}, {1'b0, stk[0]});
      end else begin
        slot = rd;
        tick(rd ? 2 : 3);
        slot = 1'b0;
        issue = 1'b0;
        chk({flush, load, pc}, {!rd, 1'b1, stk[0]});
        for (int i = 0; i < 7; i++) stk[i] = stk[i+1];
        chk(top, stk[0]);
        for (int i = 0; i < 3; i++) chk(yl[i], rd ? xl[i] : el[i]);
        for (int i = 0; i < 8; i++) chk(ys[i], rd ? xs[i] : rst_exp(i, ret_en));
      end
      $display("round %0d cmd %0d done", r, cmd);
    end
    test_done;
  end
endmodule : irup_unit_tb

bind irup_unit irup_assertions u_chk (.CLOCK_I, .RST_I, .CE_I, .ISSUE_I, .CMD_I, .USE_CARRY_I,
  .CARRY_I, .SLOT_EXEC_I, .BUSY_O, .PC_LOAD_O, .FLUSH_O, .PC_O, .STACK_TOP_O, .STATUS0_O);
